// file: masr_pkg.sv
package masr_pkg;

   // Register indices; byte address is four times the index
   localparam logic [11:0] MASR_IDX_STATE  = 12'h190;
   localparam logic [11:0] MASR_IDX_SPEED  = 12'h196;
   localparam logic [11:0] MASR_IDX_BUS_I  = 12'h410;
   localparam logic [11:0] MASR_IDX_PH_A   = 12'h440;
   localparam logic [11:0] MASR_IDX_PH_B   = 12'h442;
   localparam logic [11:0] MASR_IDX_PH_C   = 12'h444;
   localparam logic [11:0] MASR_IDX_IRQ_ST = 12'h7F0;
   localparam logic [11:0] MASR_IDX_IRQ_MK = 12'h7F1;

   localparam int          MASR_ADDR_W     = 14;
   localparam int          MASR_FRAC_BITS  = 27;
   localparam int          MASR_IBASE_DIV  = 8;

   localparam logic [15:0] MASR_STATE_RST  = 16'h0000;
   localparam logic [31:0] MASR_VALUE_RST  = 32'h00000000;
   localparam logic [3:0]  MASR_MASK_RST   = 4'h0;

   // Interrupt status bit positions
   localparam int          MASR_EV_STATE   = 0;
   localparam int          MASR_EV_FAULT   = 1;
   localparam int          MASR_EV_BADCODE = 2;
   localparam int          MASR_EV_UPDATE  = 3;
   localparam int          MASR_EV_N       = 4;

   // Sequencer codes
   localparam logic [15:0] MASR_ST_IDLE        = 16'h0000;
   localparam logic [15:0] MASR_ST_ISD         = 16'h0001;
   localparam logic [15:0] MASR_ST_FLOAT       = 16'h0002;
   localparam logic [15:0] MASR_ST_START_BRK   = 16'h0003;
   localparam logic [15:0] MASR_ST_SLOW_FIRST  = 16'h0004;
   localparam logic [15:0] MASR_ST_ALIGN       = 16'h0006;
   localparam logic [15:0] MASR_ST_OPEN_LOOP   = 16'h0007;
   localparam logic [15:0] MASR_ST_CL_PRE      = 16'h0008;
   localparam logic [15:0] MASR_ST_CL_ALIGNED  = 16'h0009;
   localparam logic [15:0] MASR_ST_CL_BRAKE    = 16'h000A;
   localparam logic [15:0] MASR_ST_SOFT_STOP   = 16'h000B;
   localparam logic [15:0] MASR_ST_STOP_BRAKE  = 16'h000C;
   localparam logic [15:0] MASR_ST_PM_FIRST    = 16'h0010;
   localparam logic [15:0] MASR_ST_PM_LAST     = 16'h0018;
   localparam logic [15:0] MASR_ST_PM_FAULT    = 16'h0018;

   typedef struct packed {
      logic [15:0] state;
      logic [31:0] speed;
      logic [31:0] bus_i;
      logic [31:0] ph_a;
      logic [31:0] ph_b;
      logic [31:0] ph_c;
   } masr_vars_t;

   typedef struct packed {
      logic [MASR_ADDR_W-1:0] address;
      logic                   read;
      logic                   write;
      logic [31:0]            writedata;
   } masr_req_t;

endpackage : masr_pkg

// file: masr_state_filter.sv
`timescale 1ns/100ps
`default_nettype none

module masr_state_filter (
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   input  wire logic [15:0] raw_code,
   output logic      [15:0] code,
   output logic             changed,
   output logic             illegal
);

   logic        legal;
   logic [15:0] next_code;
   logic        next_changed;
   logic        next_illegal;

   always_comb begin
      legal = 1'b0;
      if (raw_code <= masr_pkg::MASR_ST_SLOW_FIRST) begin
         legal = 1'b1;
      end
      if (raw_code >= masr_pkg::MASR_ST_ALIGN && raw_code <= masr_pkg::MASR_ST_CL_BRAKE) begin
         legal = 1'b1;
      end
      if (raw_code == masr_pkg::MASR_ST_SOFT_STOP || raw_code == masr_pkg::MASR_ST_STOP_BRAKE) begin
         legal = 1'b1;
      end
      if (raw_code >= masr_pkg::MASR_ST_PM_FIRST && raw_code <= masr_pkg::MASR_ST_PM_LAST) begin
         legal = 1'b1;
      end
      // Unlisted codes keep the last good value
      next_code    = legal ? raw_code : code;
      next_changed = legal && (raw_code != code);
      next_illegal = !legal;
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         code    <= masr_pkg::MASR_STATE_RST;
         changed <= 1'b0;
         illegal <= 1'b0;
      end else begin
         code    <= next_code;
         changed <= next_changed;
         illegal <= next_illegal;
      end
   end

endmodule : masr_state_filter
`default_nettype wire

// file: masr_regs.sv
`timescale 1ns/100ps
`default_nettype none

module masr_regs (
   input  wire logic                         core_clk,
   input  wire logic                         rst_n,
   // Live values from the control algorithm
   input  wire masr_pkg::masr_vars_t         algo_vars,
   input  wire logic                         algo_valid,
   // Avalon-MM slave
   input  wire logic [masr_pkg::MASR_ADDR_W-1:0] avs_address,
   input  wire logic                         avs_read,
   input  wire logic                         avs_write,
   input  wire logic [31:0]                  avs_writedata,
   input  wire logic [3:0]                   avs_byteenable,
   output logic      [31:0]                  avs_readdata,
   output logic                              avs_waitrequest,
   output logic      [1:0]                   avs_response,
   output logic                              irq
);

   localparam logic [1:0] RESP_OK     = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;

   typedef enum {MASR_IDLE, MASR_DONE} masr_bus_t;

   masr_pkg::masr_vars_t                vars;
   masr_pkg::masr_vars_t                next_vars;
   logic [15:0]                         state_code;
   logic                                state_changed;
   logic                                state_illegal;
   logic [masr_pkg::MASR_EV_N-1:0]      irq_status;
   logic [masr_pkg::MASR_EV_N-1:0]      next_irq_status;
   logic [masr_pkg::MASR_EV_N-1:0]      irq_mask;
   logic [masr_pkg::MASR_EV_N-1:0]      next_irq_mask;
   logic [masr_pkg::MASR_EV_N-1:0]      events;
   logic                                next_irq;
   masr_bus_t                           bus_st;
   masr_bus_t                           next_bus_st;
   logic [31:0]                         next_readdata;
   logic [1:0]                          next_response;
   logic                                next_waitrequest;
   logic [11:0]                         word_idx;
   logic                                clr_w;
   logic                                mask_w;

   masr_state_filter u_state (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .raw_code (algo_vars.state),
      .code     (state_code),
      .changed  (state_changed),
      .illegal  (state_illegal)
   );

   // Value snapshot; only the algorithm updates it, never the bus
   always_comb begin
      next_vars = vars;
      if (algo_valid) begin
         next_vars.speed = algo_vars.speed;
         next_vars.bus_i = algo_vars.bus_i;
         next_vars.ph_a  = algo_vars.ph_a;
         next_vars.ph_b  = algo_vars.ph_b;
         next_vars.ph_c  = algo_vars.ph_c;
      end
      next_vars.state = state_code;
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         vars.state <= masr_pkg::MASR_STATE_RST;
         vars.speed <= masr_pkg::MASR_VALUE_RST;
         vars.bus_i <= masr_pkg::MASR_VALUE_RST;
         vars.ph_a  <= masr_pkg::MASR_VALUE_RST;
         vars.ph_b  <= masr_pkg::MASR_VALUE_RST;
         vars.ph_c  <= masr_pkg::MASR_VALUE_RST;
      end else begin
         vars <= next_vars;
      end
   end

   assign word_idx = 12'(avs_address[masr_pkg::MASR_ADDR_W-1:2]);

   // Bus slave: request answered one cycle after it appears
   always_comb begin
      next_bus_st      = bus_st;
      next_readdata    = avs_readdata;
      next_response    = avs_response;
      next_waitrequest = 1'b1;
      clr_w            = 1'b0;
      mask_w           = 1'b0;
      unique case (bus_st)
         MASR_IDLE: begin
            if (avs_read || avs_write) begin
               next_bus_st      = MASR_DONE;
               next_waitrequest = 1'b0;
               next_response    = RESP_OK;
               next_readdata    = 32'h00000000;
               unique case (word_idx)
                  masr_pkg::MASR_IDX_STATE:  next_readdata = {16'h0000, vars.state};
                  masr_pkg::MASR_IDX_SPEED:  next_readdata = vars.speed;
                  masr_pkg::MASR_IDX_BUS_I:  next_readdata = vars.bus_i;
                  masr_pkg::MASR_IDX_PH_A:   next_readdata = vars.ph_a;
                  masr_pkg::MASR_IDX_PH_B:   next_readdata = vars.ph_b;
                  masr_pkg::MASR_IDX_PH_C:   next_readdata = vars.ph_c;
                  masr_pkg::MASR_IDX_IRQ_ST: begin
                     next_readdata = {28'h0000000, irq_status};
                     clr_w         = avs_write && avs_byteenable[0];
                  end
                  masr_pkg::MASR_IDX_IRQ_MK: begin
                     next_readdata = {28'h0000000, irq_mask};
                     mask_w        = avs_write && avs_byteenable[0];
                  end
                  default:                   next_response = RESP_DECERR;
               endcase
               if (avs_write) begin
                  next_readdata = 32'h00000000;
               end
            end
         end
         MASR_DONE: begin
            next_bus_st = MASR_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         bus_st          <= MASR_IDLE;
         avs_readdata    <= 32'h00000000;
         avs_response    <= 2'h0;
         avs_waitrequest <= 1'b1;
      end else begin
         bus_st          <= next_bus_st;
         avs_readdata    <= next_readdata;
         avs_response    <= next_response;
         avs_waitrequest <= next_waitrequest;
      end
   end

   // Events: state change, measurement fault entry, illegal raw code, new sample
   always_comb begin
      events = '0;
      events[masr_pkg::MASR_EV_STATE]   = state_changed;
      events[masr_pkg::MASR_EV_FAULT]   = state_changed && (state_code == masr_pkg::MASR_ST_PM_FAULT);
      events[masr_pkg::MASR_EV_BADCODE] = state_illegal;
      events[masr_pkg::MASR_EV_UPDATE]  = algo_valid;
      next_irq_mask = mask_w ? avs_writedata[masr_pkg::MASR_EV_N-1:0] : irq_mask;
      // Set beats a simultaneous write-one clear
      next_irq_status = events | (irq_status & ~(clr_w ? avs_writedata[masr_pkg::MASR_EV_N-1:0] : '0));
      next_irq = |(next_irq_status & next_irq_mask);
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_status <= '0;
         irq_mask   <= masr_pkg::MASR_MASK_RST;
         irq        <= 1'b0;
      end else begin
         irq_status <= next_irq_status;
         irq_mask   <= next_irq_mask;
         irq        <= next_irq;
      end
   end

endmodule : masr_regs
`default_nettype wire

// file: masr_regs_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module masr_regs_asserts (
   input wire logic        core_clk,
   input wire logic        rst_n,
   input wire logic        algo_valid,
   input wire logic [13:0] avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic [1:0]  avs_response,
   input wire logic        irq
);
   logic        seen_valid;
   logic        next_seen_valid;
   logic [11:0] idx;
   logic        ans;
   logic        rd_ans;
   logic        mapped;
   logic        val_reg;
   assign idx = avs_address[13:2];
   assign ans = !avs_waitrequest && (avs_read || avs_write);
   assign rd_ans = ans && avs_read;
   assign val_reg = idx inside {masr_pkg::MASR_IDX_SPEED, masr_pkg::MASR_IDX_BUS_I, masr_pkg::MASR_IDX_PH_A,
                                masr_pkg::MASR_IDX_PH_B, masr_pkg::MASR_IDX_PH_C};
   assign mapped = val_reg || idx inside {masr_pkg::MASR_IDX_STATE, masr_pkg::MASR_IDX_IRQ_ST,
                                          masr_pkg::MASR_IDX_IRQ_MK};
   // Zero on readback is only owed until the first capture
   always_comb next_seen_valid = seen_valid | algo_valid;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n)
         seen_valid <= 1'b0;
      else
         seen_valid <= next_seen_valid;
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   a_answer_next: assert property (($rose(avs_read) || $rose(avs_write)) |=> !avs_waitrequest)
      else $error("answer not given one cycle after request");
   a_answer_single: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low for more than one cycle");
   a_idle_waits: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
      else $error("answer without request");
   a_state_upper: assert property (rd_ans && idx == masr_pkg::MASR_IDX_STATE |-> avs_readdata[31:16] == 16'h0000)
      else $error("state register upper half not zero");
   a_state_legal: assert property (rd_ans && idx == masr_pkg::MASR_IDX_STATE |->
      avs_readdata[15:0] <= 16'h0018 && !(avs_readdata[15:0] inside {16'h0005, [16'h000D:16'h000F]}))
      else $error("unlisted state code reported");
   a_unmapped_err: assert property (rd_ans && !mapped |-> avs_response == 2'h3 && avs_readdata == 32'h0)
      else $error("unmapped read not refused");
   a_mapped_okay: assert property (ans && mapped |-> avs_response == 2'h0)
      else $error("mapped access not answered okay");
   a_reset_zero: assert property (rd_ans && val_reg && !seen_valid |-> avs_readdata == 32'h0)
      else $error("value register not zero after reset");
   c_state_read: cover property (rd_ans && idx == masr_pkg::MASR_IDX_STATE);
   c_unmapped: cover property (rd_ans && !mapped);
   c_irq_rise: cover property ($rose(irq));
endmodule : masr_regs_asserts
bind masr_regs masr_regs_asserts u_masr_regs_asserts (.core_clk, .rst_n, .algo_valid, .avs_address, .avs_read,
   .avs_write, .avs_readdata, .avs_waitrequest, .avs_response, .irq);
`default_nettype wire

// file: tb_masr_regs.sv
`timescale 1ns/100ps
`default_nettype none
module tb_masr_regs;
   logic                 core_clk;
   logic                 rst_n;
   masr_pkg::masr_vars_t algo_vars;
   logic                 algo_valid;
   logic [13:0]          avs_address;
   logic                 avs_read;
   logic                 avs_write;
   logic [31:0]          avs_writedata;
   logic [31:0]          avs_readdata;
   logic                 avs_waitrequest;
   logic [1:0]           avs_response;
   logic                 irq;
   int                   n_errors;
   int                   samples_checked;
   logic [31:0]          rd;
   logic [1:0]           rsp;
   logic [15:0]          last_ok;
   logic [31:0]          vals [5] = '{32'hF000_0001, 32'h8000_0000, 32'hFFFF_FFFF, 32'h0800_0000, 32'h7FFF_FFFE};
   logic [11:0]          ridx [6] = '{masr_pkg::MASR_IDX_STATE, masr_pkg::MASR_IDX_SPEED, masr_pkg::MASR_IDX_BUS_I,
                                      masr_pkg::MASR_IDX_PH_A, masr_pkg::MASR_IDX_PH_B, masr_pkg::MASR_IDX_PH_C};
   masr_regs u_masr_regs (.core_clk(core_clk), .rst_n(rst_n), .algo_vars(algo_vars), .algo_valid(algo_valid),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .avs_response(avs_response), .irq(irq));
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic acc(input logic wr, input logic [11:0] ix, input logic [31:0] wd);
      @(posedge core_clk);
      avs_address <= {ix, 2'b00};
      avs_read <= !wr;
      avs_write <= wr;
      avs_writedata <= wd;
      // Only the watchdog ends a wait that never gets an answer
      do begin
         @(posedge core_clk);
      end while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      rsp = avs_response;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : acc
   task automatic rdchk(input logic [11:0] ix, input logic [31:0] exp);
      acc(1'b0, ix, 32'h0);
      chk(rd, exp);
   endtask : rdchk
   task automatic report_and_stop;
      $display("checks=%0d errors=%0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : report_and_stop
   initial begin
      repeat (5000) @(posedge core_clk);
      n_errors++;
      report_and_stop();
   end
   initial begin
      rst_n = 1'b0;
      algo_vars = '0;
      algo_valid = 1'b0;
      avs_address = '0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = '0;
      n_errors = 0;
      samples_checked = 0;
      repeat (8) @(posedge core_clk);
      rst_n <= 1'b1;
      foreach (ridx[i]) rdchk(ridx[i], 32'h0);
      algo_vars <= {16'h0000, vals[0], vals[1], vals[2], vals[3], vals[4]};
      algo_valid <= 1'b1;
      @(posedge core_clk);
      algo_valid <= 1'b0;
      // Inputs move on but the value registers may not follow without a capture strobe
      algo_vars <= '0;
      for (int i = 1; i < 6; i++) begin
         acc(1'b1, ridx[i], ~vals[i-1]);
         rdchk(ridx[i], vals[i-1]);
      end
      acc(1'b1, masr_pkg::MASR_IDX_STATE, 32'h0000_0009);
      rdchk(masr_pkg::MASR_IDX_STATE, 32'h0);
      last_ok = 16'h0000;
      for (int c = 0; c < 16'h001B; c++) begin
         algo_vars.state <= c[15:0];
         if (c <= 16'h0018 && !(c inside {5, [16'h000D:16'h000F]})) last_ok = c[15:0];
         repeat (3) @(posedge core_clk);
         rdchk(masr_pkg::MASR_IDX_STATE, {16'h0000, last_ok});
      end
      // Park on a listed code, or the bad-code event re-arms every cycle
      algo_vars.state <= masr_pkg::MASR_ST_PM_FAULT;
      repeat (3) @(posedge core_clk);
      chk({31'h0, irq}, 32'h0);
      rdchk(masr_pkg::MASR_IDX_IRQ_MK, 32'h0);
      rdchk(masr_pkg::MASR_IDX_IRQ_ST, 32'hF);
      acc(1'b1, masr_pkg::MASR_IDX_IRQ_MK, 32'h8);
      repeat (2) @(posedge core_clk);
      chk({31'h0, irq}, 32'h1);
      acc(1'b1, masr_pkg::MASR_IDX_IRQ_ST, 32'h7);
      rdchk(masr_pkg::MASR_IDX_IRQ_ST, 32'h8);
      acc(1'b1, masr_pkg::MASR_IDX_IRQ_ST, 32'h8);
      repeat (2) @(posedge core_clk);
      chk({31'h0, irq}, 32'h0);
      rdchk(masr_pkg::MASR_IDX_IRQ_ST, 32'h0);
      acc(1'b0, 12'h001, 32'h0);
      chk(rd, 32'h0);
      chk({30'h0, rsp}, 32'h3);
      report_and_stop();
   end
endmodule : tb_masr_regs
`default_nettype wire
